// >>> fault_word_pkg.sv
`default_nettype none
package fault_word_pkg;

    // command codes seen on the management bus
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CMD_STATUS_VOUT = 8'h7a;
    localparam logic [7:0] CMD_STATUS_IOUT = 8'h7b;
    localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
    localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
    localparam logic [7:0] CMD_STATUS_COMM = 8'h7e;
    localparam logic [7:0] CMD_STATUS_MFR = 8'h80;

    // page selection values
    localparam logic [7:0] PAGE_CHAN_A = 8'h00;
    localparam logic [7:0] PAGE_CHAN_B = 8'h01;
    localparam logic [7:0] PAGE_ALL = 8'hff;
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // summary word bit positions
    localparam int BIT_VOUT = 15;
    localparam int BIT_IOUT = 14;
    localparam int BIT_INPUT = 13;
    localparam int BIT_MFR = 12;
    localparam int BIT_PGOOD = 11;
    localparam int BIT_OFF = 6;
    localparam int BIT_VOUT_OV = 5;
    localparam int BIT_IOUT_OC = 4;
    localparam int BIT_VIN_UV = 3;
    localparam int BIT_TEMP = 2;
    localparam int BIT_COMM = 1;
    localparam int BIT_OTHER = 0;

    // detailed register bit positions that feed individual summary bits
    localparam int VOUT_OVF_BIT = 7;
    localparam int VOUT_UNDER_BIT = 4;
    localparam int IOUT_OCF_BIT = 7;
    localparam int IOUT_WARN_BIT = 5;
    localparam int INPUT_UNDER_BIT = 4;

    // latched summary bits: 15..12 and 5..0
    localparam logic [15:0] LATCH_MASK = 16'hf03f;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] IDLE_WORD = 16'hffff;

    // bits per byte on the serial link
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] MAX_DATA_BYTES = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK,
        ST_WAIT
    } link_state_t;

endpackage : fault_word_pkg
`default_nettype wire

// >>> summary_latch_if.sv
`timescale 1ns/1ps
`default_nettype none
interface summary_latch_if;
    logic [15:0] set_evt;
    logic [15:0] clr_mask;
    logic [15:0] flags;

    modport bank (
        input set_evt,
        input clr_mask,
        output flags
    );

    modport user (
        output set_evt,
        output clr_mask,
        input flags
    );
endinterface : summary_latch_if
`default_nettype wire

// >>> summary_latch_bank.sv
`timescale 1ns/1ps
`default_nettype none
module summary_latch_bank (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // set and clear requests, latched flags
    summary_latch_if.bank lat
);

    typedef struct packed {
        logic [15:0] flags;
    } bank_state_t;

    bank_state_t bank_reg;
    bank_state_t bank_next;

    // a set arriving in the same cycle as its clear wins
    always_comb begin
        bank_next = bank_reg;
        bank_next.flags = ((bank_reg.flags & ~lat.clr_mask) | lat.set_evt)
                          & fault_word_pkg::LATCH_MASK;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bank_reg <= '0;
        end else begin
            bank_reg <= bank_next;
        end
    end

    assign lat.flags = bank_reg.flags;

endmodule : summary_latch_bank
`default_nettype wire

// >>> paged_fault_summary_word.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Summary word 79h is read only as a two-byte Read Word.
// - Page 00h selects channel A, page 01h selects channel B.
// - With page FFh the summary word reports channel A.
// - Bit 15 latches any output-voltage fault or warning.
// - Bit 14 latches any output-current fault or warning.
// - Bit 13 latches any input voltage or current fault or warning.
// - Bit 12 latches any vendor-specific fault.
// - Bits 10 to 7 always read zero.
// - Bit 6 live, one whenever the channel delivers no power.
// - Bit 5 latches an output overvoltage fault.
// - Bit 4 latches an output overcurrent fault.
// - Bit 3 latches input below the lockout threshold.
// - Bit 2 latches overtemperature fault or warning.
// - Bit 1 latches communication, memory or logic fault.
// - Bit 0 latches other faults such as undervoltage or overcurrent warning.
// - Any write to the summary word is an invalid transaction.
// - Writing one to a detailed status bit also clears its summary bit.
// - Latched flags hold until clear-faults or a write-one clear.
// - Invalid write sets the comm fault flag and asserts alert.
module paged_fault_summary_word #(
    parameter logic [6:0] DEV_ADDR = 7'h40
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // management bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic alert_o,
    output logic alert_oe_o,
    // channel ready pins
    input wire logic channel_a_ready_pin_i,
    input wire logic channel_b_ready_pin_i,
    // channel state from the power stage logic
    input wire logic power_on_a_i,
    input wire logic power_on_b_i,
    input wire logic [15:0] fault_event_a_i,
    input wire logic [15:0] fault_event_b_i,
    // current page for the other paged registers
    output logic [7:0] page_o
);

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_q;
        logic sda_m;
        logic sda_s;
        logic sda_q;
        logic rdy_a_m;
        logic rdy_a_s;
        logic rdy_b_m;
        logic rdy_b_s;
        fault_word_pkg::link_state_t st;
        fault_word_pkg::link_state_t ack_from;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic rd;
        logic cmd_ok;
        logic [7:0] cmd;
        logic [1:0] nbytes;
        logic [7:0] wdata;
        logic [15:0] rd_word;
        logic hi_byte;
        logic acked;
        logic bad_read;
        logic sda_low;
        logic [7:0] page;
        logic alert;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;

    summary_latch_if lat_a ();
    summary_latch_if lat_b ();

    logic [15:0] set_a;
    logic [15:0] set_b;
    logic [15:0] clr_a;
    logic [15:0] clr_b;
    logic [15:0] word_a;
    logic [15:0] word_b;

    summary_latch_bank u_bank_a (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .lat(lat_a.bank)
    );

    summary_latch_bank u_bank_b (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .lat(lat_b.bank)
    );

    assign lat_a.set_evt = set_a;
    assign lat_b.set_evt = set_b;
    assign lat_a.clr_mask = clr_a;
    assign lat_b.clr_mask = clr_b;

    // channels touched by a write: all pages means both
    function automatic logic [1:0] page_sel(input logic [7:0] page);
        logic [1:0] sel;
        sel = 2'b01;
        if (page == fault_word_pkg::PAGE_CHAN_B) begin
            sel = 2'b10;
        end else if (page == fault_word_pkg::PAGE_ALL) begin
            sel = 2'b11;
        end
        return sel;
    endfunction : page_sel

    // summary bits cleared by a write-one to a detailed status register;
    // a group bit drops on any write-one to its group, since the detailed
    // bits themselves live outside this block
    function automatic logic [15:0] w1c_mask(input logic [7:0] cmd,
                                             input logic [7:0] d);
        logic [15:0] m;
        m = 16'h0000;
        case (cmd)
            fault_word_pkg::CMD_STATUS_VOUT: begin
                m[fault_word_pkg::BIT_VOUT] = |d;
                m[fault_word_pkg::BIT_VOUT_OV] =
                    d[fault_word_pkg::VOUT_OVF_BIT];
                m[fault_word_pkg::BIT_OTHER] =
                    d[fault_word_pkg::VOUT_UNDER_BIT];
            end
            fault_word_pkg::CMD_STATUS_IOUT: begin
                m[fault_word_pkg::BIT_IOUT] = |d;
                m[fault_word_pkg::BIT_IOUT_OC] =
                    d[fault_word_pkg::IOUT_OCF_BIT];
                m[fault_word_pkg::BIT_OTHER] =
                    d[fault_word_pkg::IOUT_WARN_BIT];
            end
            fault_word_pkg::CMD_STATUS_INPUT: begin
                m[fault_word_pkg::BIT_INPUT] = |d;
                m[fault_word_pkg::BIT_VIN_UV] =
                    d[fault_word_pkg::INPUT_UNDER_BIT];
            end
            fault_word_pkg::CMD_STATUS_TEMP: begin
                m[fault_word_pkg::BIT_TEMP] = |d;
            end
            fault_word_pkg::CMD_STATUS_COMM: begin
                m[fault_word_pkg::BIT_COMM] = |d;
            end
            fault_word_pkg::CMD_STATUS_MFR: begin
                m[fault_word_pkg::BIT_MFR] = |d;
            end
            default: begin
                m = 16'h0000;
            end
        endcase
        return m;
    endfunction : w1c_mask

    // latched part from the banks, live bits 11 and 6, bits 10..7 zero
    always_comb begin
        word_a = lat_a.flags & fault_word_pkg::LATCH_MASK;
        word_a[fault_word_pkg::BIT_PGOOD] = ~s_reg.rdy_a_s;
        word_a[fault_word_pkg::BIT_OFF] = ~power_on_a_i;
        word_b = lat_b.flags & fault_word_pkg::LATCH_MASK;
        word_b[fault_word_pkg::BIT_PGOOD] = ~s_reg.rdy_b_s;
        word_b[fault_word_pkg::BIT_OFF] = ~power_on_b_i;
    end

    always_comb begin
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic inv;
        logic [1:0] sel;
        logic [15:0] m;
        logic [15:0] w;
        start = 1'b0;
        stop = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        inv = 1'b0;
        sel = 2'b01;
        m = 16'h0000;
        w = fault_word_pkg::IDLE_WORD;
        s_next = s_reg;
        // event inputs set bits 15..12 and 5..0 per channel
        set_a = fault_event_a_i & fault_word_pkg::LATCH_MASK;
        set_b = fault_event_b_i & fault_word_pkg::LATCH_MASK;
        clr_a = 16'h0000;
        clr_b = 16'h0000;

        // pins cross into the clock domain through two flops each
        s_next.scl_m = scl_i;
        s_next.scl_s = s_reg.scl_m;
        s_next.scl_q = s_reg.scl_s;
        s_next.sda_m = sda_i;
        s_next.sda_s = s_reg.sda_m;
        s_next.sda_q = s_reg.sda_s;
        s_next.rdy_a_m = channel_a_ready_pin_i;
        s_next.rdy_a_s = s_reg.rdy_a_m;
        s_next.rdy_b_m = channel_b_ready_pin_i;
        s_next.rdy_b_s = s_reg.rdy_b_m;

        start = s_reg.scl_s && s_reg.scl_q && s_reg.sda_q && !s_reg.sda_s;
        stop = s_reg.scl_s && s_reg.scl_q && !s_reg.sda_q && s_reg.sda_s;
        rise = s_reg.scl_s && !s_reg.scl_q;
        fall = !s_reg.scl_s && s_reg.scl_q;
        sel = page_sel(s_reg.page);

        // word returned on a read, taken when the read address is acked
        if (s_reg.cmd_ok && s_reg.cmd == fault_word_pkg::CMD_SUMMARY_WORD)
        begin
            w = (s_reg.page == fault_word_pkg::PAGE_CHAN_B) ?
                word_b : word_a;
        end else if (s_reg.cmd_ok && s_reg.cmd == fault_word_pkg::CMD_PAGE)
        begin
            w = {8'h00, s_reg.page};
        end

        if (start) begin
            s_next.st = fault_word_pkg::ST_ADDR;
            s_next.bitcnt = 4'h0;
            s_next.sda_low = 1'b0;
        end else if (stop) begin
            // write transactions take effect at their stop condition
            if (s_reg.cmd_ok && !s_reg.rd) begin
                case (s_reg.cmd)
                    fault_word_pkg::CMD_PAGE: begin
                        if (s_reg.nbytes == 2'h1 &&
                            (s_reg.wdata == fault_word_pkg::PAGE_CHAN_A ||
                             s_reg.wdata == fault_word_pkg::PAGE_CHAN_B ||
                             s_reg.wdata == fault_word_pkg::PAGE_ALL)) begin
                            s_next.page = s_reg.wdata;
                        end else begin
                            inv = 1'b1;
                        end
                    end
                    fault_word_pkg::CMD_CLEAR_FAULTS: begin
                        if (sel[0]) begin
                            clr_a = fault_word_pkg::LATCH_MASK;
                        end
                        if (sel[1]) begin
                            clr_b = fault_word_pkg::LATCH_MASK;
                        end
                        s_next.alert = 1'b0;
                    end
                    fault_word_pkg::CMD_SUMMARY_WORD: begin
                        inv = 1'b1;
                    end
                    fault_word_pkg::CMD_STATUS_VOUT,
                    fault_word_pkg::CMD_STATUS_IOUT,
                    fault_word_pkg::CMD_STATUS_INPUT,
                    fault_word_pkg::CMD_STATUS_TEMP,
                    fault_word_pkg::CMD_STATUS_COMM,
                    fault_word_pkg::CMD_STATUS_MFR: begin
                        if (s_reg.nbytes == 2'h1) begin
                            m = w1c_mask(s_reg.cmd, s_reg.wdata);
                            if (sel[0]) begin
                                clr_a = m;
                            end
                            if (sel[1]) begin
                                clr_b = m;
                            end
                            if (m[fault_word_pkg::BIT_COMM]) begin
                                s_next.alert = 1'b0;
                            end
                        end
                    end
                    default: begin
                        inv = 1'b0;
                    end
                endcase
            end
            if (s_reg.bad_read) begin
                inv = 1'b1;
            end
            if (inv) begin
                set_a[fault_word_pkg::BIT_COMM] |= sel[0];
                set_b[fault_word_pkg::BIT_COMM] |= sel[1];
                s_next.alert = 1'b1;
            end
            s_next.st = fault_word_pkg::ST_IDLE;
            s_next.cmd_ok = 1'b0;
            s_next.bad_read = 1'b0;
            s_next.sda_low = 1'b0;
        end else begin
            case (s_reg.st)
                fault_word_pkg::ST_ADDR,
                fault_word_pkg::ST_CMD,
                fault_word_pkg::ST_WDATA: begin
                    if (rise) begin
                        s_next.shift = {s_reg.shift[6:0], s_reg.sda_s};
                        s_next.bitcnt = s_reg.bitcnt + 4'h1;
                    end else if (fall &&
                                 s_reg.bitcnt == fault_word_pkg::BYTE_BITS)
                    begin
                        s_next.bitcnt = 4'h0;
                        s_next.ack_from = s_reg.st;
                        s_next.st = fault_word_pkg::ST_ACK;
                        s_next.sda_low = 1'b1;
                        if (s_reg.st == fault_word_pkg::ST_ADDR) begin
                            s_next.rd = s_reg.shift[0];
                            if (s_reg.shift[7:1] != DEV_ADDR) begin
                                s_next.st = fault_word_pkg::ST_WAIT;
                                s_next.sda_low = 1'b0;
                            end else if (!s_reg.shift[0]) begin
                                s_next.cmd_ok = 1'b0;
                                s_next.nbytes = 2'h0;
                            end
                        end else if (s_reg.st == fault_word_pkg::ST_CMD) begin
                            s_next.cmd = s_reg.shift;
                            s_next.cmd_ok = 1'b1;
                        end else begin
                            if (s_reg.nbytes == 2'h0) begin
                                s_next.wdata = s_reg.shift;
                            end
                            if (s_reg.nbytes != fault_word_pkg::MAX_DATA_BYTES)
                            begin
                                s_next.nbytes = s_reg.nbytes + 2'h1;
                            end
                        end
                    end
                end
                fault_word_pkg::ST_ACK: begin
                    if (fall) begin
                        s_next.sda_low = 1'b0;
                        if (s_reg.ack_from == fault_word_pkg::ST_ADDR &&
                            s_reg.rd) begin
                            // low byte goes first, both in one transaction
                            s_next.rd_word = w;
                            s_next.hi_byte = 1'b0;
                            s_next.sda_low = ~w[7];
                            s_next.shift = {w[6:0], 1'b0};
                            s_next.bitcnt = 4'h1;
                            s_next.st = fault_word_pkg::ST_RDATA;
                        end else if (s_reg.ack_from ==
                                     fault_word_pkg::ST_ADDR) begin
                            s_next.st = fault_word_pkg::ST_CMD;
                        end else begin
                            s_next.st = fault_word_pkg::ST_WDATA;
                        end
                    end
                end
                fault_word_pkg::ST_RDATA: begin
                    if (fall) begin
                        if (s_reg.bitcnt == fault_word_pkg::BYTE_BITS) begin
                            s_next.sda_low = 1'b0;
                            s_next.st = fault_word_pkg::ST_RACK;
                        end else begin
                            s_next.sda_low = ~s_reg.shift[7];
                            s_next.shift = {s_reg.shift[6:0], 1'b0};
                            s_next.bitcnt = s_reg.bitcnt + 4'h1;
                        end
                    end
                end
                fault_word_pkg::ST_RACK: begin
                    if (rise) begin
                        s_next.acked = ~s_reg.sda_s;
                    end else if (fall) begin
                        if (s_reg.acked && !s_reg.hi_byte) begin
                            s_next.hi_byte = 1'b1;
                            s_next.sda_low = ~s_reg.rd_word[15];
                            s_next.shift = {s_reg.rd_word[14:8], 1'b0};
                            s_next.bitcnt = 4'h1;
                            s_next.st = fault_word_pkg::ST_RDATA;
                        end else begin
                            s_next.st = fault_word_pkg::ST_WAIT;
                            // a one-byte read of the word is not allowed
                            if (!s_reg.hi_byte && s_reg.cmd_ok &&
                                s_reg.cmd ==
                                fault_word_pkg::CMD_SUMMARY_WORD) begin
                                s_next.bad_read = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    s_next.sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // both pins are open drain: they only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = s_reg.sda_low;
    assign alert_o = 1'b0;
    assign alert_oe_o = s_reg.alert;
    assign page_o = s_reg.page;

endmodule : paged_fault_summary_word
`default_nettype wire

// >>> fault_word_props.sv
`timescale 1ns/1ps
`default_nettype none
module fault_word_props (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // bus pins and page
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic alert_o,
    input wire logic alert_oe_o,
    input wire logic [7:0] page_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_open_drain_pins: assert property (
        sda_o == 1'b0 && alert_o == 1'b0)
        else $error("bus pin driven high");
    chk_page_legal: assert property (
        page_o == 8'h00 || page_o == 8'h01 || page_o == 8'hff)
        else $error("page holds illegal value");
    chk_page_at_stop: assert property (
        !$stable(page_o) |-> scl_i && sda_i)
        else $error("page changed inside a frame");
    // the target may only move sda while scl is low
    chk_sda_scl_low: assert property (
        $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("sda driven change while scl high");
    chk_no_false_start: assert property (
        $fell(sda_i) && scl_i && $past(scl_i) |-> !sda_oe_o)
        else $error("target made a start condition");
    chk_oe_bounded: assert property (
        sda_oe_o |-> ##[1:200] !sda_oe_o)
        else $error("sda held low too long");
    chk_alert_at_stop: assert property (
        $rose(alert_oe_o) |-> scl_i && sda_i)
        else $error("alert raised outside stop");
    chk_alert_clear_stop: assert property (
        $fell(alert_oe_o) |-> scl_i && sda_i)
        else $error("alert dropped outside stop");
endmodule : fault_word_props
`default_nettype wire

// >>> pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model #(
    parameter logic [6:0] ADDR = 7'h40
) (
    // bus pins
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    logic r;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // sda moves only mid-low so the target sees clean setup and hold
    task automatic bit_x(input logic b, output logic q);
        sda_low_o = !b;
        #12 scl_o = 1'b1;
        #12 q = sda_i;
        #12 scl_o = 1'b0;
        #12;
    endtask : bit_x
    task automatic start();
        sda_low_o = 1'b0;
        #12 scl_o = 1'b1;
        #24 sda_low_o = 1'b1;
        #24 scl_o = 1'b0;
        #12;
    endtask : start
    task automatic stop();
        sda_low_o = 1'b1;
        #12 scl_o = 1'b1;
        #24 sda_low_o = 1'b0;
        #48;
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask : rbyte
    // write byte, or send byte when has_d is low
    task automatic xfer(input logic [7:0] c, input logic [7:0] d,
                        input logic has_d, output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({ADDR, 1'b0}, a0);
        wbyte(c, a1);
        a2 = 1'b1;
        if (has_d) wbyte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : xfer
    task automatic read_word(input logic [7:0] c, output logic [15:0] w,
                             output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({ADDR, 1'b0}, a0);
        wbyte(c, a1);
        start();
        wbyte({ADDR, 1'b1}, a2);
        rbyte(1'b0, w[7:0]);
        rbyte(1'b1, w[15:8]);
        stop();
        ok = a0 & a1 & a2;
    endtask : read_word
    // one-byte read, last byte refused with a nack
    task automatic read_byte(input logic [7:0] c, output logic [7:0] d,
                             output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({ADDR, 1'b0}, a0);
        wbyte(c, a1);
        start();
        wbyte({ADDR, 1'b1}, a2);
        rbyte(1'b1, d);
        stop();
        ok = a0 & a1 & a2;
    endtask : read_byte
endmodule : pmbus_host_model
`default_nettype wire

// >>> paged_fault_summary_word_tb.sv
`timescale 1ns/1ps
`default_nettype none
module paged_fault_summary_word_tb;
    logic clock_i, sys_rst_i, rdy_a, rdy_b, pon_a, pon_b, ok;
    logic scl, host_low, sda_o, sda_oe, alert_o, alert_oe;
    logic [15:0] ev_a, ev_b, w;
    logic [7:0] page;
    wire logic sda;
    int fails = 0;
    int total_checks = 0;
    // pull-up: the line is low when any party pulls it
    assign sda = !(host_low || sda_oe);
    paged_fault_summary_word dut_u (.clock_i(clock_i),
        .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .alert_o(alert_o), .alert_oe_o(alert_oe),
        .channel_a_ready_pin_i(rdy_a), .channel_b_ready_pin_i(rdy_b),
        .power_on_a_i(pon_a), .power_on_b_i(pon_b),
        .fault_event_a_i(ev_a), .fault_event_b_i(ev_b), .page_o(page));
    pmbus_host_model host_u (.scl_o(scl), .sda_low_o(host_low),
        .sda_i(sda));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp16
    task automatic rd(input logic [15:0] exp);
        host_u.read_word(fault_word_pkg::CMD_SUMMARY_WORD, w, ok);
        cmp16({15'h0, ok}, 16'h1);
        cmp16(w, exp);
    endtask : rd
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        host_u.xfer(c, d, 1'b1, ok);
        cmp16({15'h0, ok}, 16'h1);
    endtask : wr
    task automatic clear_faults();
        host_u.xfer(fault_word_pkg::CMD_CLEAR_FAULTS, 8'h00, 1'b0, ok);
    endtask : clear_faults
    task automatic ev(input logic chan_b, input logic [15:0] m);
        @(posedge clock_i);
        #1.5;
        if (chan_b) ev_b = m;
        else ev_a = m;
        @(posedge clock_i);
        #1.5;
        ev_a = 16'h0000;
        ev_b = 16'h0000;
    endtask : ev
    task automatic t_latch();
        cmp16({8'h00, page}, 16'h0000);
        rd(16'h0000);
        ev(1'b0, 16'hffff);
        rd(16'hf03f);
        wr(fault_word_pkg::CMD_PAGE, 8'h01);
        rd(16'h0000);
        wr(fault_word_pkg::CMD_PAGE, 8'hff);
        rd(16'hf03f);
        wr(fault_word_pkg::CMD_PAGE, 8'h00);
    endtask : t_latch
    task automatic t_live();
        @(posedge clock_i);
        #1.5;
        rdy_a = 1'b0;
        pon_a = 1'b0;
        rd(16'hf87f);
        @(posedge clock_i);
        #1.5;
        rdy_a = 1'b1;
        pon_a = 1'b1;
        rd(16'hf03f);
    endtask : t_live
    task automatic t_w1c();
        logic [7:0] cm [6] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h80, 8'h7e};
        logic [7:0] dt [6] = '{8'h90, 8'h80, 8'h10, 8'h01, 8'h01, 8'h01};
        logic [15:0] ex [6] = '{16'h701e, 16'h300e, 16'h1006, 16'h1002,
                                16'h0002, 16'h0000};
        for (int i = 0; i < 6; i++) begin
            wr(cm[i], dt[i]);
            rd(ex[i]);
        end
    endtask : t_w1c
    task automatic t_bad_write();
        ev(1'b0, 16'h0020);
        host_u.xfer(fault_word_pkg::CMD_SUMMARY_WORD, 8'h00, 1'b1, ok);
        rd(16'h0022);
        cmp16({15'h0, alert_oe}, 16'h0001);
        clear_faults();
        cmp16({15'h0, alert_oe}, 16'h0000);
        rd(16'h0000);
        wr(fault_word_pkg::CMD_PAGE, 8'h05);
        cmp16({8'h00, page}, 16'h0000);
        cmp16({15'h0, alert_oe}, 16'h0001);
        rd(16'h0002);
        clear_faults();
        host_u.read_byte(fault_word_pkg::CMD_PAGE, w[7:0], ok);
        cmp16({8'h00, w[7:0]}, 16'h0000);
        host_u.read_byte(fault_word_pkg::CMD_SUMMARY_WORD, w[7:0], ok);
        cmp16({15'h0, ok}, 16'h1);
        rd(16'h0002);
        clear_faults();
    endtask : t_bad_write
    task automatic t_page_b();
        ev(1'b1, 16'h0010);
        rd(16'h0000);
        wr(fault_word_pkg::CMD_PAGE, 8'h01);
        cmp16({8'h00, page}, 16'h0001);
        rd(16'h0010);
        clear_faults();
        rd(16'h0000);
        wr(fault_word_pkg::CMD_PAGE, 8'h00);
    endtask : t_page_b
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = !clock_i;
    end
    initial begin
        repeat (100000) @(posedge clock_i);
        fails++;
        end_sim();
    end
    initial begin
        sys_rst_i = 1'b1;
        {rdy_a, rdy_b, pon_a, pon_b} = 4'hf;
        ev_a = 16'h0000;
        ev_b = 16'h0000;
        repeat (5) @(posedge clock_i);
        #1.5 sys_rst_i = 1'b0;
        repeat (6) @(posedge clock_i);
        // off-edge start keeps every bus pin change clear of rising clock edges
        #1.5;
        t_latch();
        t_live();
        t_w1c();
        t_bad_write();
        t_page_b();
        end_sim();
    end
endmodule : paged_fault_summary_word_tb
bind paged_fault_summary_word fault_word_props chk_u (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o),
    .page_o(page_o));
`default_nettype wire
